// file: hw/odc_decoder.sv
/*
 Opcode decoder subset: takes words from the fetch path, classifies them,
 gathers the second word of two-word forms and reports operation, operand
 fields, words and cycle count to the execution units.
 Assumes the fetch path holds a word until taken and that condition and index
 status come from the execution units as levels.
*/
// Functional notes
// RULE1: Nibble 0011 subtracts shifted memory, one cycle
// RULE2: 0110 0101 subtracts memory shifted sixteen
// RULE3: 1011 1010 subtracts short constant, one cycle
// RULE4: BFA plus shift: two-word long subtract
// RULE5: 0110 0100 subtracts memory and inverted carry
// RULE6: Two-word XOR: fixed sixteen or variable shift
// RULE7: 0110 1000 zeroes low, rounds into high
// RULE8: 00000 plus select loads index, two cycles
// RULE9: BF4 01 compares index with compare value
// RULE10: Page pointer loads take two cycles
// RULE11: Mask AND stores back, one or two
// RULE12: Mask compare leaves memory untouched
// RULE13: Fused multiply add: two words, three cycles
// RULE14: Top 110 multiplies by signed thirteen-bit constant
// RULE15: Unsigned product of memory and multiplicand
// RULE16: BF0 00 sets product shift mode
// RULE17: Jump four cycles, delayed two
// RULE18: Conditional jump four taken, two otherwise
// RULE19: Index-nonzero jump four taken, two otherwise
// RULE20: Jump to sum low: four, delayed two
// RULE21: Peripheral register access adds one cycle
// RULE22: Bit seven selects indirect; low seven offset
// RULE23: Fetch second word, advance past both
module odc_decoder
  import odc_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic            mclk_i,
  input  wire logic            reset_n_i,
  input  wire logic            clk_en_i,
  input  wire logic [31:0]     wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic            wb_we_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [15:0]     fetch_word_i,
  input  wire logic            fetch_valid_i,
  output logic                 fetch_ready_o,
  output logic      [PC_W-1:0] fetch_pc_o,
  input  wire logic            cond_true_i,
  input  wire logic            index_nonzero_i,
  input  wire logic            exec_ready_i,
  output logic                 exec_valid_o,
  output odc_op_t              exec_op_o,
  output logic      [15:0]     exec_word_o,
  output logic      [15:0]     exec_const_o,
  output logic      [3:0]      exec_shift_o,
  output logic      [2:0]      exec_index_sel_o,
  output logic                 exec_indirect_o,
  output logic      [6:0]      exec_addr_o,
  output logic      [1:0]      exec_words_o,
  output logic      [2:0]      exec_cycles_o,
  output logic                 exec_jump_o,
  output logic      [1:0]      product_shift_mode_o
);

  odc_state_t      state;
  odc_op_t         dec_op;
  logic            dec_two;
  logic [2:0]      dec_cyc;
  logic            dec_mem;
  logic [15:0]     first_word;
  logic [31:0]     ctrl;
  logic [15:0]     count;
  logic [1:0]      product_shift_mode;

  // Memory-reference forms carry an operand address field
  function automatic logic uses_mem(input odc_op_t op);
    uses_mem = (op == ODC_OP_SUB_SHF) || (op == ODC_OP_SUB_16) || (op == ODC_OP_SUB_BRW) ||
               (op == ODC_OP_RND_LOAD) || (op == ODC_OP_LOAD_IDX) || (op == ODC_OP_LDP_DMA) ||
               (op == ODC_OP_MASK_AND) || (op == ODC_OP_MASK_ANDK) || (op == ODC_OP_MASK_CMP) ||
               (op == ODC_OP_FMA) || (op == ODC_OP_MPY_U);
  endfunction

  // Decode the word waiting on the fetch path
  always_comb begin
    logic [15:0] w;
    w       = fetch_word_i;
    dec_op  = ODC_OP_NONE;
    dec_two = 1'b0;
    dec_cyc = ODC_CYC_1;
    if (w[15:12] == ODC_NIB_SUB_SHF) begin
      dec_op = ODC_OP_SUB_SHF; // RULE1
    end else if (w[15:13] == ODC_TOP_MPY_K) begin
      dec_op = ODC_OP_MPY_K; // RULE14
    end else if (w[15:11] == ODC_TOP_LOAD_IDX) begin
      dec_op  = ODC_OP_LOAD_IDX; // RULE8
      dec_cyc = ODC_CYC_2;
    end else if (w[15:9] == ODC_TOP_LDP_IMM) begin
      dec_op  = ODC_OP_LDP_IMM; // RULE10
      dec_cyc = ODC_CYC_2;
    end else if (w[15:10] == ODC_TOP_JMP_C) begin
      dec_op  = ODC_OP_JMP_C; // RULE18
      dec_two = 1'b1;
      dec_cyc = cond_true_i ? ODC_CYC_4 : ODC_CYC_2;
    end else if (w[15:10] == ODC_TOP_JMP_CD) begin
      dec_op  = ODC_OP_JMP_CD; // RULE18
      dec_two = 1'b1;
      dec_cyc = ODC_CYC_2;
    end else if (w[15:8] == ODC_HB_SUB_16) begin
      dec_op = ODC_OP_SUB_16; // RULE2
    end else if (w[15:8] == ODC_HB_SUB_SK) begin
      dec_op = ODC_OP_SUB_SK; // RULE3
    end else if (w[15:8] == ODC_HB_SUB_BRW) begin
      dec_op = ODC_OP_SUB_BRW; // RULE5
    end else if (w[15:8] == ODC_HB_RND) begin
      dec_op = ODC_OP_RND_LOAD; // RULE7
    end else if (w[15:8] == ODC_HB_LDP_DMA) begin
      dec_op  = ODC_OP_LDP_DMA; // RULE10
      dec_cyc = ODC_CYC_2;
    end else if (w[15:8] == ODC_HB_MASK_AND) begin
      dec_op = ODC_OP_MASK_AND; // RULE11
    end else if (w[15:8] == ODC_HB_MASK_ANDK) begin
      dec_op  = ODC_OP_MASK_ANDK; // RULE11
      dec_two = 1'b1;
      dec_cyc = ODC_CYC_2;
    end else if (w[15:8] == ODC_HB_MASK_CMP) begin
      dec_op = ODC_OP_MASK_CMP; // RULE12
    end else if (w[15:8] == ODC_HB_FMA) begin
      dec_op  = ODC_OP_FMA; // RULE13
      dec_two = 1'b1;
      dec_cyc = ODC_CYC_3;
    end else if (w[15:8] == ODC_HB_MPY_U) begin
      dec_op = ODC_OP_MPY_U; // RULE15
    end else if (w[15:8] == ODC_HB_JMP) begin
      dec_op  = ODC_OP_JMP; // RULE17
      dec_two = 1'b1;
      dec_cyc = ODC_CYC_4;
    end else if (w[15:8] == ODC_HB_JMP_D) begin
      dec_op  = ODC_OP_JMP_D; // RULE17
      dec_two = 1'b1;
      dec_cyc = ODC_CYC_2;
    end else if (w[15:8] == ODC_HB_JMP_NZ) begin
      dec_op  = ODC_OP_JMP_NZ; // RULE19
      dec_two = 1'b1;
      dec_cyc = index_nonzero_i ? ODC_CYC_4 : ODC_CYC_2;
    end else if (w[15:8] == ODC_HB_JMP_NZD) begin
      dec_op  = ODC_OP_JMP_NZD; // RULE19
      dec_two = 1'b1;
      dec_cyc = ODC_CYC_2;
    end else if (w[15:8] == ODC_HB_EXT_E) begin
      if (w[7:0] == ODC_LB_XOR_LK16) begin
        dec_op  = ODC_OP_XOR_LK16; // RULE6
        dec_two = 1'b1;
        dec_cyc = ODC_CYC_2;
      end else if (w[7:0] == ODC_LB_JMP_ACC) begin
        dec_op  = ODC_OP_JMP_ACC; // RULE20
        dec_cyc = ODC_CYC_4;
      end else if (w[7:0] == ODC_LB_JMP_ACCD) begin
        dec_op  = ODC_OP_JMP_ACCD; // RULE20
        dec_cyc = ODC_CYC_2;
      end
    end else if (w[15:8] == ODC_HB_EXT_F) begin
      if (w[7:4] == ODC_LN_SUB_LK) begin
        dec_op  = ODC_OP_SUB_LK; // RULE4
        dec_two = 1'b1;
        dec_cyc = ODC_CYC_2;
      end else if (w[7:4] == ODC_LN_XOR_LKS) begin
        dec_op  = ODC_OP_XOR_LKS; // RULE6
        dec_two = 1'b1;
        dec_cyc = ODC_CYC_2;
      end else if (w[7:2] == ODC_LB6_IDX_CMP) begin
        dec_op = ODC_OP_IDX_CMP; // RULE9
      end else if (w[7:2] == ODC_LB6_SET_PM) begin
        dec_op = ODC_OP_SET_PM; // RULE16
      end
    end
    // Direct addressing into the peripheral window costs one extra cycle
    dec_mem = uses_mem(dec_op) && !w[7] && (w[6:0] >= ODC_PERIPH_LO) && (w[6:0] <= ODC_PERIPH_HI);
    if (dec_mem) begin
      dec_cyc = dec_cyc + ODC_CYC_1; // RULE21
    end
  end

  // Fetch is held off while frozen or while a result waits, so a word is never dropped
  assign fetch_ready_o = clk_en_i && ctrl[ODC_CTRL_EN] && (state != ODC_ST_EXEC);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state            <= ODC_ST_IDLE;
      first_word       <= 16'h0000;
      fetch_pc_o       <= '0;
      exec_op_o        <= ODC_OP_NONE;
      exec_word_o      <= 16'h0000;
      exec_const_o     <= 16'h0000;
      exec_shift_o     <= 4'h0;
      exec_index_sel_o <= 3'h0;
      exec_indirect_o  <= 1'b0;
      exec_addr_o      <= 7'h00;
      exec_words_o     <= 2'd0;
      exec_cycles_o    <= 3'd0;
      exec_jump_o      <= 1'b0;
    end else if (clk_en_i) begin
      case (state)
        ODC_ST_IDLE: begin
          if (fetch_valid_i && fetch_ready_o) begin
            fetch_pc_o       <= fetch_pc_o + 1'b1; // RULE23
            first_word       <= fetch_word_i;
            exec_op_o        <= dec_op;
            exec_word_o      <= fetch_word_i;
            exec_const_o     <= {{8{1'b0}}, fetch_word_i[7:0]};
            exec_shift_o     <= (dec_op == ODC_OP_SUB_SHF) ? fetch_word_i[11:8] : fetch_word_i[3:0];
            exec_index_sel_o <= fetch_word_i[10:8];
            exec_indirect_o  <= fetch_word_i[7]; // RULE22
            exec_addr_o      <= fetch_word_i[6:0]; // RULE22
            exec_words_o     <= dec_two ? 2'd2 : 2'd1;
            exec_cycles_o    <= dec_cyc;
            exec_jump_o      <= (dec_op == ODC_OP_JMP) || (dec_op == ODC_OP_JMP_D) ||
                                (dec_op == ODC_OP_JMP_ACC) || (dec_op == ODC_OP_JMP_ACCD) ||
                                (dec_op == ODC_OP_JMP_CD) || (dec_op == ODC_OP_JMP_NZD) ||
                                ((dec_op == ODC_OP_JMP_C) && cond_true_i) ||
                                ((dec_op == ODC_OP_JMP_NZ) && index_nonzero_i);
            if (dec_op == ODC_OP_MPY_K) begin
              exec_const_o <= {{3{fetch_word_i[12]}}, fetch_word_i[12:0]}; // RULE14
            end else if (dec_op == ODC_OP_LDP_IMM) begin
              exec_const_o <= {7'h00, fetch_word_i[8:0]}; // RULE10
            end
            state <= dec_two ? ODC_ST_WORD : ODC_ST_EXEC;
          end
        end
        ODC_ST_WORD: begin
          if (fetch_valid_i && fetch_ready_o) begin
            fetch_pc_o   <= fetch_pc_o + 1'b1; // RULE23
            exec_const_o <= fetch_word_i; // RULE23
            state        <= ODC_ST_EXEC;
          end
        end
        ODC_ST_EXEC: begin
          if (exec_ready_i) begin
            state <= ODC_ST_IDLE;
          end
        end
        default: state <= ODC_ST_IDLE;
      endcase
    end
  end

  assign exec_valid_o = (state == ODC_ST_EXEC);

  // Product shift mode steers every product-to-sum move
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      product_shift_mode <= 2'b00;
    end else if (clk_en_i && exec_valid_o && exec_ready_i && (exec_op_o == ODC_OP_SET_PM)) begin
      product_shift_mode <= exec_word_o[1:0]; // RULE16
    end
  end
  assign product_shift_mode_o = product_shift_mode;

  // Instruction counter; a software clear loses to a retiring instruction
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 16'h0000;
    end else if (clk_en_i) begin
      if (exec_valid_o && exec_ready_i) begin
        count <= count + 1'b1;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_adr_i[3:0] == ODC_ADR_COUNT)) begin
        count <= 16'h0000;
      end
    end
  end

  // Wishbone slave: one wait state, ack drops after one cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl     <= ODC_RST_CTRL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      // Writes land on the edge at which the master samples ack
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_adr_i[3:0] == ODC_ADR_CTRL) && wb_sel_i[0]) begin
        ctrl <= {31'h0, wb_dat_i[ODC_CTRL_EN]};
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_adr_i[3:0] == ODC_ADR_CTRL) begin
          wb_dat_o <= ctrl;
        end else if (wb_adr_i[3:0] == ODC_ADR_STATUS) begin
          wb_dat_o <= {19'h0, exec_op_o, exec_cycles_o, exec_words_o, state, exec_valid_o};
        end else if (wb_adr_i[3:0] == ODC_ADR_PMODE) begin
          wb_dat_o <= {30'h0, product_shift_mode};
        end else if (wb_adr_i[3:0] == ODC_ADR_COUNT) begin
          wb_dat_o <= {16'h0, count};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

endmodule

// file: inc/odc_pkg.sv
/*
 Package for the opcode decoder subset: opcode patterns, operation codes,
 cycle counts, register offsets and field positions.
 Assumes one 25 MHz clock domain.
*/
package odc_pkg;
  // Operation codes presented to the execution units
  typedef enum logic [4:0] {
    ODC_OP_NONE      = 5'h00,
    ODC_OP_SUB_SHF   = 5'h01,
    ODC_OP_SUB_16    = 5'h02,
    ODC_OP_SUB_SK    = 5'h03,
    ODC_OP_SUB_LK    = 5'h04,
    ODC_OP_SUB_BRW   = 5'h05,
    ODC_OP_XOR_LK16  = 5'h06,
    ODC_OP_XOR_LKS   = 5'h07,
    ODC_OP_RND_LOAD  = 5'h08,
    ODC_OP_LOAD_IDX  = 5'h09,
    ODC_OP_IDX_CMP   = 5'h0a,
    ODC_OP_LDP_DMA   = 5'h0b,
    ODC_OP_LDP_IMM   = 5'h0c,
    ODC_OP_MASK_AND  = 5'h0d,
    ODC_OP_MASK_ANDK = 5'h0e,
    ODC_OP_MASK_CMP  = 5'h0f,
    ODC_OP_FMA       = 5'h10,
    ODC_OP_MPY_K     = 5'h11,
    ODC_OP_MPY_U     = 5'h12,
    ODC_OP_SET_PM    = 5'h13,
    ODC_OP_JMP       = 5'h14,
    ODC_OP_JMP_D     = 5'h15,
    ODC_OP_JMP_C     = 5'h16,
    ODC_OP_JMP_CD    = 5'h17,
    ODC_OP_JMP_NZ    = 5'h18,
    ODC_OP_JMP_NZD   = 5'h19,
    ODC_OP_JMP_ACC   = 5'h1a,
    ODC_OP_JMP_ACCD  = 5'h1b
  } odc_op_t;

  typedef enum logic [1:0] {
    ODC_ST_IDLE = 2'b00,
    ODC_ST_WORD = 2'b01,
    ODC_ST_EXEC = 2'b10
  } odc_state_t;

  // Opcode patterns
  localparam logic [3:0] ODC_NIB_SUB_SHF  = 4'h3;
  localparam logic [2:0] ODC_TOP_MPY_K    = 3'h6;
  localparam logic [4:0] ODC_TOP_LOAD_IDX = 5'h00;
  localparam logic [6:0] ODC_TOP_LDP_IMM  = 7'h5e;
  localparam logic [7:0] ODC_HB_SUB_16    = 8'h65;
  localparam logic [7:0] ODC_HB_SUB_SK    = 8'hba;
  localparam logic [7:0] ODC_HB_SUB_BRW   = 8'h64;
  localparam logic [7:0] ODC_HB_RND       = 8'h68;
  localparam logic [7:0] ODC_HB_LDP_DMA   = 8'h0d;
  localparam logic [7:0] ODC_HB_MASK_AND  = 8'h5a;
  localparam logic [7:0] ODC_HB_MASK_ANDK = 8'h5e;
  localparam logic [7:0] ODC_HB_MASK_CMP  = 8'h5b;
  localparam logic [7:0] ODC_HB_FMA       = 8'ha2;
  localparam logic [7:0] ODC_HB_MPY_U     = 8'h55;
  localparam logic [7:0] ODC_HB_JMP       = 8'h79;
  localparam logic [7:0] ODC_HB_JMP_D     = 8'h7d;
  localparam logic [7:0] ODC_HB_JMP_NZ    = 8'h7b;
  localparam logic [7:0] ODC_HB_JMP_NZD   = 8'h7f;
  localparam logic [7:0] ODC_HB_EXT_E     = 8'hbe;
  localparam logic [7:0] ODC_HB_EXT_F     = 8'hbf;
  localparam logic [5:0] ODC_TOP_JMP_C    = 6'h38;
  localparam logic [5:0] ODC_TOP_JMP_CD   = 6'h3c;
  localparam logic [7:0] ODC_LB_XOR_LK16  = 8'h83;
  localparam logic [7:0] ODC_LB_JMP_ACC   = 8'h20;
  localparam logic [7:0] ODC_LB_JMP_ACCD  = 8'h21;
  localparam logic [3:0] ODC_LN_SUB_LK    = 4'ha;
  localparam logic [3:0] ODC_LN_XOR_LKS   = 4'hd;
  localparam logic [5:0] ODC_LB6_IDX_CMP  = 6'h11;
  localparam logic [5:0] ODC_LB6_SET_PM   = 6'h00;

  // Cycle counts
  localparam logic [2:0] ODC_CYC_1 = 3'd1;
  localparam logic [2:0] ODC_CYC_2 = 3'd2;
  localparam logic [2:0] ODC_CYC_3 = 3'd3;
  localparam logic [2:0] ODC_CYC_4 = 3'd4;

  // Peripheral register window in data memory
  localparam logic [6:0] ODC_PERIPH_LO = 7'h20;
  localparam logic [6:0] ODC_PERIPH_HI = 7'h4f;

  // Register offsets (byte addresses)
  localparam logic [3:0] ODC_ADR_CTRL   = 4'h0;
  localparam logic [3:0] ODC_ADR_STATUS = 4'h4;
  localparam logic [3:0] ODC_ADR_PMODE  = 4'h8;
  localparam logic [3:0] ODC_ADR_COUNT  = 4'hc;
  localparam int         ODC_CTRL_EN    = 0;
  localparam int         ODC_CTRL_CNZ   = 1;
  localparam int         ODC_CTRL_CFLG  = 4;
  localparam logic [31:0] ODC_RST_CTRL  = 32'h0000_0001;
endpackage

// file: sim/odc_decoder_monitor.sv
/*
 Checker of decoder fetch and execute relations.
 Assumes it is bound into odc_decoder and sees only its ports.
*/
module odc_decoder_monitor
  import odc_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic            mclk_i,
  input wire logic            reset_n_i,
  input wire logic            clk_en_i,
  input wire logic            fetch_valid_i,
  input wire logic            fetch_ready_o,
  input wire logic [PC_W-1:0] fetch_pc_o,
  input wire logic            exec_ready_i,
  input wire logic            exec_valid_o,
  input wire odc_op_t         exec_op_o,
  input wire logic [15:0]     exec_word_o,
  input wire logic [15:0]     exec_const_o,
  input wire logic [3:0]      exec_shift_o,
  input wire logic            exec_indirect_o,
  input wire logic [6:0]      exec_addr_o,
  input wire logic [1:0]      exec_words_o,
  input wire logic [2:0]      exec_cycles_o,
  input wire logic            exec_jump_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic pe;
  // Indirect forms never pay the peripheral cycle
  assign pe = !exec_indirect_o && exec_addr_o >= ODC_PERIPH_LO && exec_addr_o <= ODC_PERIPH_HI;
  property p_pc; fetch_valid_i && fetch_ready_o && clk_en_i |=> fetch_pc_o == $past(fetch_pc_o) + 1'b1; endproperty
  a_pc: assert property (p_pc) else $error("pc did not step");
  property p_hold; exec_valid_o && !exec_ready_i && clk_en_i |=> exec_valid_o && $stable(exec_op_o); endproperty
  a_hold: assert property (p_hold) else $error("exec output dropped early");
  property p_busy; exec_valid_o |-> !fetch_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("fetch taken while busy");
  property p_shf; exec_valid_o && exec_op_o == ODC_OP_SUB_SHF |-> exec_shift_o == exec_word_o[11:8]
    && exec_cycles_o == (pe ? ODC_CYC_2 : ODC_CYC_1); endproperty
  a_shf: assert property (p_shf) else $error("shifted subtract wrong");
  property p_lk; exec_valid_o && exec_op_o == ODC_OP_SUB_LK |-> exec_words_o == 2'd2
    && exec_cycles_o == ODC_CYC_2 && exec_shift_o == exec_word_o[3:0]; endproperty
  a_lk: assert property (p_lk) else $error("long subtract wrong");
  property p_mpk; exec_valid_o && exec_op_o == ODC_OP_MPY_K |-> exec_cycles_o == ODC_CYC_1
    && exec_const_o == {{3{exec_word_o[12]}}, exec_word_o[12:0]}; endproperty
  a_mpk: assert property (p_mpk) else $error("constant multiply wrong");
  property p_fma; exec_valid_o && exec_op_o == ODC_OP_FMA |-> exec_words_o == 2'd2
    && exec_cycles_o == (pe ? ODC_CYC_4 : ODC_CYC_3); endproperty
  a_fma: assert property (p_fma) else $error("multiply add wrong");
  property p_cnd; exec_valid_o && exec_op_o inside {ODC_OP_JMP_C, ODC_OP_JMP_NZ}
    |-> exec_cycles_o == (exec_jump_o ? ODC_CYC_4 : ODC_CYC_2); endproperty
  a_cnd: assert property (p_cnd) else $error("tested jump cycles wrong");
  property p_j4; exec_valid_o && exec_op_o inside {ODC_OP_JMP, ODC_OP_JMP_ACC} |-> exec_cycles_o == ODC_CYC_4; endproperty
  a_j4: assert property (p_j4) else $error("jump cycles wrong");
  property p_dly; exec_valid_o && exec_op_o inside {ODC_OP_JMP_D, ODC_OP_JMP_CD, ODC_OP_JMP_NZD, ODC_OP_JMP_ACCD}
    |-> exec_cycles_o == ODC_CYC_2; endproperty
  a_dly: assert property (p_dly) else $error("delayed jump cycles wrong");
endmodule
bind odc_decoder odc_decoder_monitor #(.PC_W(PC_W)) u_odc_decoder_monitor (.mclk_i, .reset_n_i, .clk_en_i,
  .fetch_valid_i, .fetch_ready_o, .fetch_pc_o, .exec_ready_i, .exec_valid_o, .exec_op_o, .exec_word_o,
  .exec_const_o, .exec_shift_o, .exec_indirect_o, .exec_addr_o, .exec_words_o, .exec_cycles_o, .exec_jump_o);

// file: sim/odc_fetch_model.sv
/*
 Stand-in for the fetch path and execution units.
 Assumes the bench fills the word queue; the stall length keeps its default of 2.
*/
module odc_fetch_model (
  input  wire logic        mclk_i,
  input  wire logic        fetch_ready_i,
  input  wire logic        exec_valid_i,
  output logic      [15:0] fetch_word_o,
  output logic             fetch_valid_o,
  output logic             exec_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words[$];
  int          stall = 2;
  int          wait_n = 0;
  initial begin
    fetch_word_o = 16'h0;
    fetch_valid_o = 1'b0;
    exec_ready_o = 1'b0;
  end
  // Idle word toggles so stale data never looks valid
  always @(posedge mclk_i) begin
    if (fetch_valid_o && fetch_ready_i)
      void'(words.pop_front());
    if (words.size() > 0) begin
      fetch_valid_o <= 1'b1;
      fetch_word_o  <= words[0];
    end else begin
      fetch_valid_o <= 1'b0;
      fetch_word_o  <= ~fetch_word_o;
    end
    exec_ready_o <= exec_valid_i && !exec_ready_o && wait_n >= stall;
    wait_n       <= (exec_valid_i && !exec_ready_o) ? wait_n + 1 : 0;
  end
endmodule

// file: sim/odc_decoder_tb_top.sv
/*
 Self-checking bench for the opcode decoder subset.
 Assumes package, decoder, checker and fetch model are compiled first.
*/
module odc_decoder_tb_top
  import odc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, cond_true_i = 1'b0, index_nonzero_i = 1'b0;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, fetch_valid_i, fetch_ready_o;
  logic        exec_ready_i, exec_valid_o, exec_indirect_o, exec_jump_o;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0]  wb_sel_i = 4'hf, exec_shift_o;
  logic [15:0] fetch_word_i, fetch_pc_o, exec_word_o, exec_const_o;
  logic [6:0]  exec_addr_o;
  logic [2:0]  exec_index_sel_o, exec_cycles_o;
  logic [1:0]  exec_words_o, product_shift_mode_o;
  odc_op_t     exec_op_o;
  int          err_count = 0, n_checks = 0, n_ret = 0, n_words = 0;
  odc_decoder u_odc_decoder (.mclk_i, .reset_n_i, .clk_en_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .fetch_word_i, .fetch_valid_i, .fetch_ready_o, .fetch_pc_o, .cond_true_i,
    .index_nonzero_i, .exec_ready_i, .exec_valid_o, .exec_op_o, .exec_word_o, .exec_const_o, .exec_shift_o,
    .exec_index_sel_o, .exec_indirect_o, .exec_addr_o, .exec_words_o, .exec_cycles_o, .exec_jump_o,
    .product_shift_mode_o);
  odc_fetch_model u_odc_fetch_model (.mclk_i, .fetch_ready_i(fetch_ready_o), .exec_valid_i(exec_valid_o),
    .fetch_word_o(fetch_word_i), .fetch_valid_o(fetch_valid_i), .exec_ready_o(exec_ready_i));
  initial forever #20 mclk_i = ~mclk_i;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    check(32'h0, 32'h1, what);
    finish_test();
  endtask
  task automatic wait_ev(input logic lvl);
    for (int n = 0; exec_valid_o !== lvl; n++) begin
      @(negedge mclk_i);
      if (n > 60) hang("exec wait");
    end
  endtask
  task automatic run(input logic [15:0] w1, w2, input logic two, input odc_op_t op, input logic [2:0] cyc);
    wait_ev(1'b0);
    @(negedge mclk_i);
    u_odc_fetch_model.words.push_back(w1);
    if (two)
      u_odc_fetch_model.words.push_back(w2);
    wait_ev(1'b1);
    n_ret++;
    n_words += two ? 2 : 1;
    check(32'(fetch_pc_o), 32'(n_words), "pc");
    check(32'(exec_op_o), 32'(op), "op");
    check(32'(exec_words_o), two ? 32'h2 : 32'h1, "words");
    check(32'(exec_cycles_o), 32'(cyc), "cycles");
  endtask
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
    @(posedge mclk_i);
    wb_adr_i <= {28'h0, a};
    wb_we_i  <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (int n = 0; n == 0 || wb_ack_o !== 1'b1; n++) begin
      @(posedge mclk_i);
      if (n > 20) hang("bus ack");
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    check(rd, e, "register");
  endtask
  task automatic t_regs();
    rchk(ODC_ADR_CTRL, ODC_RST_CTRL);
    rchk(ODC_ADR_STATUS, 32'h0);
    wb(4'h2, 1'b1, 32'h0);
    rchk(4'h2, 32'h0);
    rchk(ODC_ADR_CTRL, ODC_RST_CTRL);
    wb(ODC_ADR_CTRL, 1'b1, 32'h0);
    @(negedge mclk_i);
    check(32'(fetch_ready_o), 32'h0, "ready while off");
    wb(ODC_ADR_CTRL, 1'b1, 32'h1);
  endtask
  task automatic t_hold();
    @(posedge mclk_i);
    clk_en_i <= 1'b0;
    @(negedge mclk_i);
    u_odc_fetch_model.words.push_back(16'h5510);
    repeat (4) @(negedge mclk_i);
    check(32'(fetch_ready_o), 32'h0, "ready while frozen");
    check(32'({exec_valid_o, fetch_pc_o}), 32'(n_words), "state while frozen");
    @(posedge mclk_i);
    clk_en_i <= 1'b1;
    wait_ev(1'b1);
    n_ret++;
    n_words++;
    check(32'(exec_op_o), 32'(ODC_OP_MPY_U), "op after freeze");
  endtask
  task automatic t_acc();
    run(16'h3a05, 16'h0, 1'b0, ODC_OP_SUB_SHF, ODC_CYC_1);
    check(32'(exec_shift_o), 32'ha, "shift");
    run(16'h3aa5, 16'h0, 1'b0, ODC_OP_SUB_SHF, ODC_CYC_1);
    check(32'({exec_indirect_o, exec_addr_o}), 32'ha5, "mode and offset");
    run(16'h6520, 16'h0, 1'b0, ODC_OP_SUB_16, ODC_CYC_2);
    run(16'h654f, 16'h0, 1'b0, ODC_OP_SUB_16, ODC_CYC_2);
    run(16'h6550, 16'h0, 1'b0, ODC_OP_SUB_16, ODC_CYC_1);
    run(16'hba7f, 16'h0, 1'b0, ODC_OP_SUB_SK, ODC_CYC_1);
    check(32'(exec_const_o), 32'h7f, "const");
    run(16'hbfa3, 16'h1234, 1'b1, ODC_OP_SUB_LK, ODC_CYC_2);
    check(32'(exec_const_o), 32'h1234, "const");
    run(16'h6410, 16'h0, 1'b0, ODC_OP_SUB_BRW, ODC_CYC_1);
    run(16'hbe83, 16'h5555, 1'b1, ODC_OP_XOR_LK16, ODC_CYC_2);
    run(16'hbfd5, 16'haaaa, 1'b1, ODC_OP_XOR_LKS, ODC_CYC_2);
    check(32'(exec_shift_o), 32'h5, "shift");
    run(16'h6810, 16'h0, 1'b0, ODC_OP_RND_LOAD, ODC_CYC_1);
  endtask
  task automatic t_index();
    for (int i = 0; i < 8; i++) begin
      run({5'h00, 3'(i), 8'h10}, 16'h0, 1'b0, ODC_OP_LOAD_IDX, ODC_CYC_2);
      check(32'(exec_index_sel_o), 32'(i), "index");
    end
    for (int i = 0; i < 4; i++)
      run({14'h2fd1, 2'(i)}, 16'h0, 1'b0, ODC_OP_IDX_CMP, ODC_CYC_1);
    run(16'hbd23, 16'h0, 1'b0, ODC_OP_LDP_IMM, ODC_CYC_2);
    check(32'(exec_const_o), 32'h123, "page");
    run(16'h0d30, 16'h0, 1'b0, ODC_OP_LDP_DMA, ODC_CYC_3);
    run(16'h5a10, 16'h0, 1'b0, ODC_OP_MASK_AND, ODC_CYC_1);
    run(16'h5e90, 16'h00ff, 1'b1, ODC_OP_MASK_ANDK, ODC_CYC_2);
    run(16'h5b10, 16'h0, 1'b0, ODC_OP_MASK_CMP, ODC_CYC_1);
  endtask
  task automatic t_mult();
    run(16'ha210, 16'h0200, 1'b1, ODC_OP_FMA, ODC_CYC_3);
    check(32'(exec_const_o), 32'h200, "const");
    run(16'hd001, 16'h0, 1'b0, ODC_OP_MPY_K, ODC_CYC_1);
    check(32'(exec_const_o), 32'hf001, "const");
    run(16'h5510, 16'h0, 1'b0, ODC_OP_MPY_U, ODC_CYC_1);
    for (int i = 0; i < 4; i++) begin
      run({14'h2fc0, 2'(i)}, 16'h0, 1'b0, ODC_OP_SET_PM, ODC_CYC_1);
      wait_ev(1'b0);
      rchk(ODC_ADR_PMODE, 32'(i));
      check(32'(product_shift_mode_o), 32'(i), "mode");
    end
  endtask
  task automatic t_jump();
    run(16'h7980, 16'h0100, 1'b1, ODC_OP_JMP, ODC_CYC_4);
    run(16'h7d80, 16'h0100, 1'b1, ODC_OP_JMP_D, ODC_CYC_2);
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk_i);
      cond_true_i     <= c[0];
      index_nonzero_i <= c[0];
      run(16'he0ff, 16'h0100, 1'b1, ODC_OP_JMP_C, c ? ODC_CYC_4 : ODC_CYC_2);
      check(32'(exec_jump_o), 32'(c), "jump");
      run(16'h7b80, 16'h0100, 1'b1, ODC_OP_JMP_NZ, c ? ODC_CYC_4 : ODC_CYC_2);
      check(32'(exec_jump_o), 32'(c), "jump");
    end
    run(16'hf0ff, 16'h0100, 1'b1, ODC_OP_JMP_CD, ODC_CYC_2);
    run(16'h7f80, 16'h0100, 1'b1, ODC_OP_JMP_NZD, ODC_CYC_2);
    run(16'hbe20, 16'h0, 1'b0, ODC_OP_JMP_ACC, ODC_CYC_4);
    run(16'hbe21, 16'h0, 1'b0, ODC_OP_JMP_ACCD, ODC_CYC_2);
    run(16'h8b00, 16'h0, 1'b0, ODC_OP_NONE, ODC_CYC_1);
    wait_ev(1'b0);
    rchk(ODC_ADR_COUNT, 32'(n_ret));
    wb(ODC_ADR_COUNT, 1'b1, 32'h0);
    rchk(ODC_ADR_COUNT, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_hold();
    t_acc();
    t_index();
    t_mult();
    t_jump();
    finish_test();
  end
endmodule
